// >>> shared/dnr_pkg.sv
package dnr_pkg;
  // register byte addresses on the serial configuration port
  localparam logic [7:0] ADDR_OSC3_LOW = 8'h0B;
  localparam logic [7:0] ADDR_OSC3_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_OSC4_LOW = 8'h0D;
  localparam logic [7:0] ADDR_OSC4_HIGH = 8'h0E;
  localparam logic [7:0] ADDR_CHOICE_SRC = 8'h0F;
  localparam logic [7:0] ADDR_CHOICE_CODE = 8'h10;
  localparam logic [7:0] ADDR_REINIT_MODE = 8'h11;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // field positions and widths
  localparam int CHOICE_SRC_BIT = 0;
  localparam int CODE_W = 2;
  localparam int FREQ_W = 16;
  // one frequency step is fs / 2**FREQ_SHIFT
  localparam int FREQ_SHIFT = 16;
  // multiframe resets that each get a reinit pulse after a divider resync in first-double mode
  localparam logic [1:0] DOUBLE_PULSES = 2'h2;

  typedef enum logic [1:0] {
    OSC_ONE = 2'b00,
    OSC_TWO = 2'b01,
    OSC_THREE = 2'b10
  } dnr_osc_t;

  typedef enum logic [1:0] {
    MODE_EVERY = 2'b00,
    MODE_FIRST_RESYNC = 2'b01,
    MODE_FIRST_DOUBLE = 2'b10,
    MODE_START_ONLY = 2'b11
  } dnr_mode_t;

  // register access request (write or read) from the serial port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dnr_req_t;

  // synchronisation events seen by the reinit sequencer
  typedef struct packed {
    logic mf_reset;
    logic ddc_start;
    logic div_resync;
  } dnr_evt_t;
endpackage

// >>> src/dnr_reinit_seq.sv
`timescale 1ns/1ps
`default_nettype none
// decides when downconverters and oscillators get reinitialised
module dnr_reinit_seq
  import dnr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // synchronous reset, low active
  input wire dnr_mode_t mode, // reinit mode field
  input wire dnr_evt_t evt, // sync event pulses
  output logic reinit // one-cycle reinit pulse, registered
);
  logic armed; // waiting for first multiframe reset after start
  logic next_armed;
  logic [1:0] pend; // multiframe resets still owed after a resync
  logic [1:0] next_pend;
  logic next_reinit;

  // next state of the sequencer
  always_comb begin
    next_armed = armed;
    next_pend = pend;
    next_reinit = 1'b0;
    if (evt.ddc_start) begin
      next_armed = 1'b1;
    end
    unique case (mode)
      MODE_EVERY: begin
        next_reinit = evt.mf_reset;
        next_pend = 2'h0;
      end
      MODE_FIRST_RESYNC: begin
        next_pend = 2'h0;
        if (armed && evt.mf_reset) begin
          next_reinit = 1'b1;
          next_armed = evt.ddc_start;
        end else if (!armed && evt.div_resync) begin
          next_reinit = 1'b1;
        end
      end
      MODE_FIRST_DOUBLE: begin
        if (armed && evt.mf_reset) begin
          next_reinit = 1'b1;
          next_armed = evt.ddc_start;
        end else if (!armed && evt.div_resync) begin
          next_pend = DOUBLE_PULSES;
        end else if (pend != 2'h0 && evt.mf_reset) begin
          next_reinit = 1'b1;
          next_pend = pend - 2'h1;
        end
      end
      MODE_START_ONLY: begin
        // multiframe resets ignored; latency not deterministic here
        next_reinit = evt.ddc_start;
        next_armed = 1'b0;
        next_pend = 2'h0;
      end
    endcase
  end

  // register sequencer state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      armed <= 1'b0;
      pend <= 2'h0;
      reinit <= 1'b0;
    end else begin
      armed <= next_armed;
      pend <= next_pend;
      reinit <= next_reinit;
    end
  end

  every_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    (mode == MODE_EVERY && $stable(mode) && evt.mf_reset) |=> reinit)
    else $error("reinit missed on multiframe reset");
  start_only_a: assert property (@(posedge clk) disable iff (!rstn)
    (mode == MODE_START_ONLY && !evt.ddc_start) |=> !reinit)
    else $error("reinit without start in start-only mode");
endmodule
`default_nettype wire

// >>> src/dnr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dnr_regs
  import dnr_pkg::*;
(
  input wire logic clk, // system clock, 40 MHz
  input wire logic rstn, // synchronous reset, low active
  input wire dnr_req_t req, // decoded serial port access
  input wire logic [CODE_W-1:0] pin_choice, // oscillator choice from gpio pins
  input wire logic dual_band_en, // channel dual band enable
  input wire dnr_evt_t evt, // multiframe, start and resync pulses
  output logic [7:0] rdata, // read data, registered
  output logic rvalid, // read data valid pulse
  output logic [FREQ_W-1:0] osc3_freq, // first band oscillator three word
  output logic [FREQ_W-1:0] osc4_freq, // second band word, zero when single band
  output logic osc4_active, // second band oscillator running
  output logic [CODE_W-1:0] active_osc, // oscillator in use on first band
  output logic reinit // reinit pulse to downconverters and oscillators
);
  logic [7:0] osc3_low, osc3_high, osc4_low, osc4_high; // frequency bytes
  logic [7:0] next_osc3_low, next_osc3_high, next_osc4_low, next_osc4_high;
  logic choice_src; // 1 selects the pins
  logic next_choice_src;
  logic [CODE_W-1:0] choice_code; // register oscillator code
  logic [CODE_W-1:0] next_choice_code;
  dnr_mode_t mode; // reinit mode field
  dnr_mode_t next_mode;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [FREQ_W-1:0] next_osc3_freq, next_osc4_freq;
  logic next_osc4_active;
  logic [CODE_W-1:0] raw_choice; // code before filtering 11
  logic [CODE_W-1:0] next_active_osc;

  // register writes; upper bits of narrow registers are discarded,
  // software is expected to write them as zero anyway
  always_comb begin
    next_osc3_low = osc3_low;
    next_osc3_high = osc3_high;
    next_osc4_low = osc4_low;
    next_osc4_high = osc4_high;
    next_choice_src = choice_src;
    next_choice_code = choice_code;
    next_mode = mode;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_OSC3_LOW: next_osc3_low = req.wdata;
        ADDR_OSC3_HIGH: next_osc3_high = req.wdata;
        ADDR_OSC4_LOW: next_osc4_low = req.wdata;
        ADDR_OSC4_HIGH: next_osc4_high = req.wdata;
        ADDR_CHOICE_SRC: next_choice_src = req.wdata[CHOICE_SRC_BIT];
        ADDR_CHOICE_CODE: next_choice_code = req.wdata[CODE_W-1:0];
        ADDR_REINIT_MODE: next_mode = dnr_mode_t'(req.wdata[1:0]);
        default: ; // unmapped writes ignored
      endcase
    end
  end

  // read path; write-only zero bits read back as zero
  always_comb begin
    next_rvalid = req.rd;
    next_rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_OSC3_LOW: next_rdata = osc3_low;
        ADDR_OSC3_HIGH: next_rdata = osc3_high;
        ADDR_OSC4_LOW: next_rdata = osc4_low;
        ADDR_OSC4_HIGH: next_rdata = osc4_high;
        ADDR_CHOICE_SRC: next_rdata = {7'h00, choice_src};
        ADDR_CHOICE_CODE: next_rdata = {6'h00, choice_code};
        ADDR_REINIT_MODE: next_rdata = {6'h00, mode};
        default: next_rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  // datapath outputs: words are raw phase steps of fs/2^16 each
  always_comb begin
    next_osc3_freq = {osc3_high, osc3_low};
    // gate band two so a stale word cannot leak in single band
    next_osc4_active = dual_band_en;
    next_osc4_freq = dual_band_en ? {osc4_high, osc4_low} : 16'h0000;
    raw_choice = choice_src ? pin_choice : choice_code;
    // undefined code 11 holds the last valid oscillator
    next_active_osc = (raw_choice == 2'h3) ? active_osc : raw_choice;
  end

  // register all state and outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc3_low <= RST_BYTE;
      osc3_high <= RST_BYTE;
      osc4_low <= RST_BYTE;
      osc4_high <= RST_BYTE;
      choice_src <= 1'b0;
      choice_code <= 2'h0;
      mode <= MODE_EVERY;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      osc3_freq <= 16'h0000;
      osc4_freq <= 16'h0000;
      osc4_active <= 1'b0;
      active_osc <= 2'h0;
    end else begin
      osc3_low <= next_osc3_low;
      osc3_high <= next_osc3_high;
      osc4_low <= next_osc4_low;
      osc4_high <= next_osc4_high;
      choice_src <= next_choice_src;
      choice_code <= next_choice_code;
      mode <= next_mode;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      osc3_freq <= next_osc3_freq;
      osc4_freq <= next_osc4_freq;
      osc4_active <= next_osc4_active;
      active_osc <= next_active_osc;
    end
  end

  // reinit sequencing lives in its own module
  dnr_reinit_seq u_seq (
    .clk(clk),
    .rstn(rstn),
    .mode(mode),
    .evt(evt),
    .reinit(reinit)
  );

  osc3_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (req.wr && req.addr == ADDR_OSC3_LOW) |-> ##2 osc3_freq[7:0] == $past(req.wdata, 2))
    else $error("oscillator three low byte not applied");
  single_band_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(dual_band_en) |-> (osc4_freq == 16'h0000 && !osc4_active))
    else $error("band two word visible in single band");
  pin_choice_a: assert property (@(posedge clk) disable iff (!rstn)
    (choice_src && pin_choice != 2'h3) |=> active_osc == $past(pin_choice))
    else $error("pin choice not followed");
  reg_choice_a: assert property (@(posedge clk) disable iff (!rstn)
    (!choice_src && choice_code != 2'h3) |=> active_osc == $past(choice_code))
    else $error("register choice not followed");
  hold_code_a: assert property (@(posedge clk) disable iff (!rstn)
    (raw_choice == 2'h3) |=> $stable(active_osc))
    else $error("code 11 changed the oscillator");
  mode_read_a: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && req.addr == ADDR_REINIT_MODE) |=> rvalid && rdata[7:2] == 6'h00)
    else $error("mode register upper bits not zero");
endmodule
`default_nettype wire

// >>> verif/dnr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host on the serial configuration port, one-cycle strobes
module dnr_host_model
  import dnr_pkg::*;
(
  input wire logic clk, // system clock
  output dnr_req_t req // access towards the bank
);
  initial req = '0;
  // raw byte write, also used for refused accesses
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    // released bus shows inverted leftovers, not a stale copy
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // field write keeps unused upper bits at zero
  task automatic wr_field(input logic [7:0] a, input logic [1:0] f);
    wr(a, {6'h00, f});
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
endmodule
`default_nettype wire

// >>> verif/dnr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dnr_regs_tb;
  import dnr_pkg::*;
  logic clk; // 40 MHz
  logic rstn; // sync reset, low active
  dnr_req_t req; // from host model
  logic [1:0] pin_choice; // gpio choice
  logic dual_band_en; // band mode
  dnr_evt_t evt; // sync event pulses
  logic [7:0] rdata;
  logic rvalid;
  logic [15:0] osc3_freq;
  logic [15:0] osc4_freq;
  logic osc4_active;
  logic [1:0] active_osc;
  logic reinit;
  int fails;
  int n_checks;
  // {mode, events, expected reinit}
  localparam logic [5:0] STEPS [15] = '{6'h09, 6'h09, 6'h14, 6'h19, 6'h18, 6'h13, 6'h24, 6'h29,
    6'h28, 6'h22, 6'h29, 6'h29, 6'h28, 6'h38, 6'h35};
  dnr_host_model host (.clk(clk), .req(req));
  dnr_regs dut (.clk(clk), .rstn(rstn), .req(req), .pin_choice(pin_choice), .dual_band_en(dual_band_en),
    .evt(evt), .rdata(rdata), .rvalid(rvalid), .osc3_freq(osc3_freq), .osc4_freq(osc4_freq),
    .osc4_active(osc4_active), .active_osc(active_osc), .reinit(reinit));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count, report at once
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // read data stands only for the cycle after the read edge, so judge it
  // at the falling edge where the host releases the strobe
  task automatic read_exp(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a);
    chk("rvalid", 16'(rvalid), 16'h0001);
    chk("rdata", 16'(rdata), 16'(exp));
  endtask
  task automatic reset_values;
    for (int a = 8'h0B; a <= 8'h11; a++) begin
      read_exp(8'(a), RST_BYTE);
    end
  endtask
  // second band word hidden until dual band is on
  task automatic freq_words;
    host.wr(ADDR_OSC3_LOW, 8'hA5);
    host.wr(ADDR_OSC3_HIGH, 8'h3C);
    host.wr(ADDR_OSC4_LOW, 8'h5A);
    host.wr(ADDR_OSC4_HIGH, 8'hC3);
    wait_n(1);
    chk("osc3_freq", osc3_freq, 16'h3CA5);
    chk("osc4_freq", osc4_freq, 16'h0000);
    chk("osc4_active", 16'(osc4_active), 16'h0000);
    dual_band_en = 1'b1;
    wait_n(2);
    chk("osc4_freq", osc4_freq, 16'hC35A);
    chk("osc4_active", 16'(osc4_active), 16'h0001);
    read_exp(ADDR_OSC3_HIGH, 8'h3C);
    read_exp(ADDR_OSC4_LOW, 8'h5A);
    host.wr(8'h12, 8'hFF);
    read_exp(8'h12, 8'h00);
  endtask
  task automatic osc_choice;
    host.wr_field(ADDR_CHOICE_SRC, 2'h0);
    for (int c = 0; c < 3; c++) begin
      host.wr_field(ADDR_CHOICE_CODE, 2'(c));
      wait_n(1);
      chk("active_osc", 16'(active_osc), 16'(c));
    end
    host.wr_field(ADDR_CHOICE_CODE, 2'h3);
    wait_n(2);
    chk("active_osc", 16'(active_osc), 16'(OSC_THREE));
    pin_choice = 2'h1;
    host.wr_field(ADDR_CHOICE_SRC, 2'h1);
    host.wr_field(ADDR_CHOICE_CODE, 2'h0);
    wait_n(1);
    chk("active_osc", 16'(active_osc), 16'h0001);
    // upper bits refused, bit 0 clear falls back to the code
    host.wr(ADDR_CHOICE_SRC, 8'hFE);
    wait_n(1);
    chk("active_osc", 16'(active_osc), 16'h0000);
    read_exp(ADDR_CHOICE_SRC, 8'h00);
  endtask
  // one pulse per step, reinit looked at the cycle after
  task automatic reinit_modes;
    logic [1:0] cur;
    cur = 2'h3;
    foreach (STEPS[i]) begin
      if (STEPS[i][5:4] !== cur) begin
        cur = STEPS[i][5:4];
        host.wr_field(ADDR_REINIT_MODE, cur);
        wait_n(1);
      end
      evt = dnr_evt_t'(STEPS[i][3:1]);
      @(negedge clk);
      evt = '0;
      chk("reinit", 16'(reinit), 16'(STEPS[i][0]));
      @(negedge clk);
      chk("reinit idle", 16'(reinit), 16'h0000);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    pin_choice = 2'h0;
    dual_band_en = 1'b0;
    evt = '0;
    fails = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    reset_values();
    freq_words();
    osc_choice();
    reinit_modes();
    give_verdict();
  end
  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    #(25 * 4000);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
